// File: design/flash_guard_defines.svh
// Flash access guard: register offsets, field positions, reset values
// and timing counts. Assumes inclusion by bare name from design files.
`ifndef FLASH_GUARD_DEFINES_SVH
`define FLASH_GUARD_DEFINES_SVH

// Register offsets on the register port
`define ADDR_CTRL1      16'h0128
`define ADDR_CTRL2      16'h012a
`define ADDR_CTRL3      16'h012c
`define ADDR_CTRL4      16'h01be
`define ADDR_IE         16'h0000

// Password bytes and the substitute opcode
`define KEY_WRITE       8'ha5
`define KEY_READ        8'h96
`define HALT_OPCODE     16'h3fff

// First control register fields
`define C1_ERASE        1
`define C1_MASS         2
`define C1_EEI          3
`define C1_ABORT        4
`define C1_WRT          6
`define C1_BLK          7
`define C1_WMASK        8'hde
`define CTRL1_RST       8'h00

// Second control register fields
`define C2_DIV_MSB      5
`define CTRL2_RST       8'h42

// Third control register fields
`define C3_BUSY         0
`define C3_KEY_VIOLATION_FLAG         1
`define C3_ACCV         2
`define C3_WAIT         3
`define C3_LOCK         4
`define C3_EMERGENCY_EXIT_BIT         5
`define C3_SEGL         6
`define C3_FAIL         7
`define C3_LOCK_RST     1'b1
`define C3_SEGL_RST     1'b1

// Fourth control register and interrupt enable fields
`define C4_MRG_PROG     4
`define C4_MRG_ERASED   5
`define IE_ACCV         5

// Timing generator tick counts
`define YIELD_TICKS     6'd32
`define WRITE_TICKS_DEF 30
`define BLK_TICKS_DEF   25
`define SEG_TICKS_DEF   4096
`define MASS_TICKS_DEF  8192

`endif

// File: design/flash_guard_pkg.sv
// Flash access guard: types for the operation sequencer and its state.
// Assumes no other package.
package flash_guard_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WRITE    = 3'b001,
    ST_BLK_PROG = 3'b010,
    ST_BLK_WAIT = 3'b011,
    ST_ERASE    = 3'b100,
    ST_SUSP     = 3'b101
  } op_state_t;

  typedef struct packed {
    op_state_t   st;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic        lock;
    logic        emergency_exit_bit;
    logic        seg_lock;
    logic        accv;
    logic        key_violation_flag;
    logic        fail;
    logic        mrg_prog;
    logic        mrg_erased;
    logic        ie_accv;
    logic        erase_seg;
    logic [5:0]  div_cnt;
    logic [15:0] op_cnt;
    logic [5:0]  yield_cnt;
    logic [15:0] reg_rdata;
    logic [15:0] cpu_rdata;
    logic        arr_prog;
    logic        arr_erase;
    logic        arr_mass;
    logic        arr_active;
    logic [15:0] arr_addr;
    logic [15:0] arr_wdata;
    logic        power_up_clear_reset;
  } guard_state_t;

endpackage

// File: design/flash_access_guard.sv
// Flash access guard: access control and operation sequencing of the
// on-chip flash controller. Assumes CPU, register port, interrupt
// inputs and flash array all run on clk; array_rdata answers cpu_addr
// in the same cycle.
`timescale 1ns/100ps
`include "flash_guard_defines.svh"

////////////////////////////////////////////////////////////////////////
// How it works
// - Flash write with write disabled flags violation
// - Fetches return halt opcode during operation
// - Busy data reads return halt opcode, silently except while a block word programs
// - Writes during erase or write: discarded, flagged
// - Bad block-write access sets violation and lock
// - Block write with word ready programs cleanly
// - Interrupts masked during operation unless allowed
// - Abort enable plus interrupt aborts, sets fail
// - Segment erase yields every 32 ticks
// - Yielding erase stays busy, accesses normal
// - System reset aborts a running erase
// - Emergency exit halts all, clears first register
// - Instruction fetch turns marginal read off
// - Two margin read select bits
// - Bad password sets key flag, resets
// - Control register reads show 96h upper byte
// - First register write violations during write, erase or block word programming
// - Second register write while busy flagged
// - Register reads always allowed, never flagged
// - Violation flag drives non-maskable request
// - Busy set from start to completion
// - Word ready shows next block word
// - Key flag cleared only by power-on
module flash_access_guard #(
  parameter int WRITE_TICKS = `WRITE_TICKS_DEF,
  parameter int BLK_TICKS   = `BLK_TICKS_DEF,
  parameter int SEG_TICKS   = `SEG_TICKS_DEF,
  parameter int MASS_TICKS  = `MASS_TICKS_DEF
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [15:0] reg_rdata,
  input  wire logic        cpu_req,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_fetch,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  output      logic [15:0] cpu_rdata,
  input  wire logic [15:0] array_rdata,
  input  wire logic        global_interrupt_enable,
  input  wire logic        irq_pending,
  output      logic        irq_mask,
  output      logic        nmi_req,
  output      logic        puc_req,
  output      logic        busy,
  output      logic        arr_prog,
  output      logic        arr_erase,
  output      logic        arr_mass,
  output      logic        arr_active,
  output      logic [15:0] arr_addr,
  output      logic [15:0] arr_wdata,
  output      logic [1:0]  arr_margin
);

  if (WRITE_TICKS < 1 || WRITE_TICKS > 65535 ||
      BLK_TICKS < 1 || BLK_TICKS > 65535 ||
      SEG_TICKS < 1 || SEG_TICKS > 65535 ||
      MASS_TICKS < 1 || MASS_TICKS > 65535) begin : g_bad_ticks
    $error("tick counts must lie in 1..65535");
  end

  localparam logic [15:0] WRITE_CNT = 16'(WRITE_TICKS);
  localparam logic [15:0] BLK_CNT   = 16'(BLK_TICKS);
  localparam logic [15:0] SEG_CNT   = 16'(SEG_TICKS);
  localparam logic [15:0] MASS_CNT  = 16'(MASS_TICKS);

  flash_guard_pkg::guard_state_t s_r;
  flash_guard_pkg::guard_state_t s_nxt;

  function automatic flash_guard_pkg::guard_state_t reset_state();
    flash_guard_pkg::guard_state_t v;
    v          = '0;
    v.st       = flash_guard_pkg::ST_IDLE;
    v.ctrl1    = `CTRL1_RST;
    v.ctrl2    = `CTRL2_RST;
    v.lock     = `C3_LOCK_RST;
    v.seg_lock = `C3_SEGL_RST;
    return v;
  endfunction

  // Constant power-on image, shared by the key violation reset
  localparam flash_guard_pkg::guard_state_t RST_STATE = reset_state();

  logic        busy_c;
  logic        frozen;
  logic        blk_mode;
  logic        word_ready;
  logic        normal_op;
  logic        tick;
  logic        accv_set;
  logic        lock_set;
  logic        subst;
  logic        key_ok;
  logic        ctrl_hit;
  logic        puc_now;
  logic        abort_now;
  logic        flash_wr;
  logic [15:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // Decodes of the current state and of the CPU and register port inputs

  always_comb begin
    busy_c     = s_r.st != flash_guard_pkg::ST_IDLE;
    // A yielding erase lets the CPU reach the array as usual
    frozen     = busy_c && s_r.st != flash_guard_pkg::ST_SUSP;
    blk_mode   = s_r.st == flash_guard_pkg::ST_BLK_PROG ||
                 s_r.st == flash_guard_pkg::ST_BLK_WAIT;
    word_ready = s_r.st == flash_guard_pkg::ST_IDLE ||
                 s_r.st == flash_guard_pkg::ST_BLK_WAIT;
    normal_op  = s_r.st == flash_guard_pkg::ST_WRITE ||
                 s_r.st == flash_guard_pkg::ST_ERASE;
    abort_now  = busy_c && s_r.ctrl1[`C1_ABORT] && global_interrupt_enable && irq_pending;
    tick       = s_r.div_cnt >= s_r.ctrl2[`C2_DIV_MSB:0];
    flash_wr   = cpu_req && cpu_wr && !cpu_fetch;
    key_ok     = reg_wdata[15:8] == `KEY_WRITE;
    ctrl_hit   = reg_addr == `ADDR_CTRL1 || reg_addr == `ADDR_CTRL2 ||
                 reg_addr == `ADDR_CTRL3 || reg_addr == `ADDR_CTRL4;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read view

  always_comb begin
    unique case (reg_addr)
      `ADDR_CTRL1: rd_mux = {`KEY_READ, s_r.ctrl1};
      `ADDR_CTRL2: rd_mux = {`KEY_READ, s_r.ctrl2};
      `ADDR_CTRL3: rd_mux = {`KEY_READ, s_r.fail, s_r.seg_lock, s_r.emergency_exit_bit,
                             s_r.lock, word_ready, s_r.accv, s_r.key_violation_flag,
                             busy_c};
      `ADDR_CTRL4: rd_mux = {`KEY_READ, 2'b00, s_r.mrg_erased,
                             s_r.mrg_prog, 4'h0};
      `ADDR_IE:    rd_mux = {10'h000, s_r.ie_accv, 5'h00};
      default:     rd_mux = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt           = s_r;
    s_nxt.arr_prog  = 1'b0;
    s_nxt.arr_erase = 1'b0;
    s_nxt.power_up_clear_reset       = 1'b0;
    accv_set        = 1'b0;
    lock_set        = 1'b0;
    subst           = 1'b0;
    puc_now         = 1'b0;

    // Timing generator enable
    s_nxt.div_cnt = tick ? 6'h00 : s_r.div_cnt + 6'h01;

    // CPU access to the array
    if (cpu_req && frozen) begin
      // Wrong-time block access: flag, lock, hand back the halt word
      if (blk_mode && (!word_ready || cpu_fetch)) begin
        accv_set = 1'b1;
        lock_set = 1'b1;
        subst    = 1'b1;
      end else if (cpu_wr && !cpu_fetch) begin
        if (normal_op) begin
          accv_set = 1'b1;
        end
      end else begin
        subst = 1'b1;
      end
    end else if (flash_wr && !busy_c) begin
      if (!s_r.ctrl1[`C1_WRT] || s_r.lock || s_r.emergency_exit_bit) begin
        accv_set = 1'b1;
      end
    end
    // Only reads and fetches refresh the returned word
    if (cpu_req && (!cpu_wr || cpu_fetch)) begin
      s_nxt.cpu_rdata = subst ? `HALT_OPCODE : array_rdata;
    end

    // Register reads never raise a flag
    if (reg_rd) begin
      s_nxt.reg_rdata = rd_mux;
    end

    // Register writes
    if (reg_wr && ctrl_hit && !key_ok) begin
      puc_now = 1'b1;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ADDR_CTRL1: begin
          if (normal_op || (blk_mode && !word_ready)) begin
            accv_set = 1'b1;
          end else begin
            s_nxt.ctrl1 = reg_wdata[7:0] & `C1_WMASK;
          end
        end
        `ADDR_CTRL2: begin
          if (busy_c) begin
            accv_set = 1'b1;
          end else begin
            s_nxt.ctrl2 = reg_wdata[7:0];
          end
        end
        `ADDR_CTRL3: begin
          s_nxt.lock     = reg_wdata[`C3_LOCK];
          s_nxt.emergency_exit_bit     = reg_wdata[`C3_EMERGENCY_EXIT_BIT];
          s_nxt.seg_lock = reg_wdata[`C3_SEGL];
          // Status flags clear only when written as zero
          if (!reg_wdata[`C3_ACCV]) begin
            s_nxt.accv = 1'b0;
          end
          if (!reg_wdata[`C3_FAIL]) begin
            s_nxt.fail = 1'b0;
          end
        end
        `ADDR_CTRL4: begin
          s_nxt.mrg_prog   = reg_wdata[`C4_MRG_PROG];
          s_nxt.mrg_erased = reg_wdata[`C4_MRG_ERASED];
        end
        `ADDR_IE: s_nxt.ie_accv = reg_wdata[`IE_ACCV];
        default: ;
      endcase
    end

    // Code run from the array drops marginal read
    if (cpu_req && cpu_fetch) begin
      s_nxt.mrg_prog   = 1'b0;
      s_nxt.mrg_erased = 1'b0;
    end

    // Operation sequencer
    unique case (s_r.st)
      flash_guard_pkg::ST_IDLE: begin
        if (flash_wr && s_r.ctrl1[`C1_WRT] && !s_r.lock && !s_r.emergency_exit_bit) begin
          s_nxt.arr_addr  = cpu_addr;
          s_nxt.arr_wdata = cpu_wdata;
          s_nxt.yield_cnt = 6'h00;
          if (s_r.ctrl1[`C1_ERASE] || s_r.ctrl1[`C1_MASS]) begin
            s_nxt.st        = flash_guard_pkg::ST_ERASE;
            s_nxt.arr_erase = 1'b1;
            s_nxt.arr_mass  = s_r.ctrl1[`C1_MASS];
            s_nxt.erase_seg = !s_r.ctrl1[`C1_MASS];
            s_nxt.op_cnt    = s_r.ctrl1[`C1_MASS] ? MASS_CNT : SEG_CNT;
          end else if (s_r.ctrl1[`C1_BLK]) begin
            s_nxt.st       = flash_guard_pkg::ST_BLK_PROG;
            s_nxt.arr_prog = 1'b1;
            s_nxt.op_cnt   = BLK_CNT;
          end else begin
            s_nxt.st       = flash_guard_pkg::ST_WRITE;
            s_nxt.arr_prog = 1'b1;
            s_nxt.op_cnt   = WRITE_CNT;
          end
        end
      end
      flash_guard_pkg::ST_WRITE,
      flash_guard_pkg::ST_BLK_PROG: begin
        if (tick) begin
          s_nxt.op_cnt = s_r.op_cnt - 16'h0001;
          if (s_r.op_cnt == 16'h0001) begin
            s_nxt.st = (s_r.st == flash_guard_pkg::ST_WRITE) ?
                       flash_guard_pkg::ST_IDLE :
                       flash_guard_pkg::ST_BLK_WAIT;
          end
        end
      end
      flash_guard_pkg::ST_BLK_WAIT: begin
        if (flash_wr) begin
          s_nxt.st        = flash_guard_pkg::ST_BLK_PROG;
          s_nxt.arr_prog  = 1'b1;
          s_nxt.arr_addr  = cpu_addr;
          s_nxt.arr_wdata = cpu_wdata;
          s_nxt.op_cnt    = BLK_CNT;
        end else if (!s_r.ctrl1[`C1_BLK]) begin
          s_nxt.st = flash_guard_pkg::ST_IDLE;
        end
      end
      flash_guard_pkg::ST_ERASE: begin
        if (tick) begin
          s_nxt.op_cnt = s_r.op_cnt - 16'h0001;
          if (s_r.yield_cnt < `YIELD_TICKS) begin
            s_nxt.yield_cnt = s_r.yield_cnt + 6'h01;
          end
        end
        if (tick && s_r.op_cnt == 16'h0001) begin
          s_nxt.st = flash_guard_pkg::ST_IDLE;
        end else if (s_r.erase_seg && s_r.ctrl1[`C1_EEI] && global_interrupt_enable &&
                     !s_r.ctrl1[`C1_ABORT] && irq_pending &&
                     s_r.yield_cnt >= `YIELD_TICKS) begin
          s_nxt.st = flash_guard_pkg::ST_SUSP;
        end
      end
      flash_guard_pkg::ST_SUSP: begin
        // Resume once the pending request has been served
        if (!irq_pending) begin
          s_nxt.st        = flash_guard_pkg::ST_ERASE;
          s_nxt.yield_cnt = 6'h00;
        end
      end
      default: s_nxt.st = flash_guard_pkg::ST_IDLE;
    endcase

    // Interrupt abort
    if (abort_now) begin
      s_nxt.st   = flash_guard_pkg::ST_IDLE;
      s_nxt.fail = 1'b1;
    end

    // Emergency exit holds the sequencer stopped
    if (s_nxt.emergency_exit_bit) begin
      s_nxt.st        = flash_guard_pkg::ST_IDLE;
      s_nxt.ctrl1     = 8'h00;
      s_nxt.arr_prog  = 1'b0;
      s_nxt.arr_erase = 1'b0;
    end

    // Flag sets win over a software clear
    if (accv_set) begin
      s_nxt.accv = 1'b1;
    end
    if (lock_set) begin
      s_nxt.lock = 1'b1;
    end

    // Array voltage is off while idle and while an erase yields
    s_nxt.arr_active = s_nxt.st != flash_guard_pkg::ST_IDLE &&
                       s_nxt.st != flash_guard_pkg::ST_SUSP;

    // Key violation: clear-state reset that keeps the key flag
    if (puc_now) begin
      s_nxt      = RST_STATE;
      s_nxt.key_violation_flag = 1'b1;
      s_nxt.power_up_clear_reset  = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata  = s_r.reg_rdata;
  assign cpu_rdata  = s_r.cpu_rdata;
  assign busy       = busy_c;
  assign puc_req    = s_r.power_up_clear_reset;
  assign arr_prog   = s_r.arr_prog;
  assign arr_erase  = s_r.arr_erase;
  assign arr_mass   = s_r.arr_mass;
  assign arr_active = s_r.arr_active;
  assign arr_addr   = s_r.arr_addr;
  assign arr_wdata  = s_r.arr_wdata;
  assign arr_margin = {s_r.mrg_erased, s_r.mrg_prog};
  assign nmi_req    = s_r.accv && s_r.ie_accv;
  // A yielding erase unmasks so that the pending request is served
  assign irq_mask   = busy_c && !s_r.ctrl1[`C1_ABORT] &&
                      s_r.st != flash_guard_pkg::ST_SUSP;

endmodule

// File: sim/flash_guard_monitor.sv
// Checker: port-level relations of the flash access guard.
// Assumes clk is the only clock and reset is asynchronous, active high.
`timescale 1ns/100ps
`include "flash_guard_defines.svh"
module flash_guard_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        cpu_req,
  input wire logic        cpu_wr,
  input wire logic        cpu_fetch,
  input wire logic [15:0] cpu_rdata,
  input wire logic        irq_mask,
  input wire logic        nmi_req,
  input wire logic        puc_req,
  input wire logic        busy,
  input wire logic        arr_prog,
  input wire logic [1:0]  arr_margin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////
  AST_RD_KEY: assert property (
    reg_rd && (reg_addr == `ADDR_CTRL1 || reg_addr == `ADDR_CTRL2 ||
    reg_addr == `ADDR_CTRL3) |=> reg_rdata[15:8] == `KEY_READ)
    else $error("control read upper byte wrong");
  AST_BAD_KEY: assert property (
    reg_wr && reg_addr == `ADDR_CTRL1 && reg_wdata[15:8] != `KEY_WRITE
    |=> puc_req ##1 !puc_req)
    else $error("bad key gave no single reset pulse");
  AST_HALT: assert property (
    cpu_req && !cpu_wr && !cpu_fetch && busy && irq_mask
    |=> cpu_rdata == `HALT_OPCODE)
    else $error("busy read did not return halt opcode");
  AST_FETCH_MRG: assert property (
    cpu_req && cpu_fetch |=> arr_margin == 2'b00)
    else $error("fetch left margin read on");
  AST_NMI_HOLD: assert property (
    nmi_req && !reg_wr && !$past(reg_wr) && !puc_req |=> nmi_req)
    else $error("violation request dropped without software");
  AST_PROG_BUSY: assert property (
    arr_prog |-> busy)
    else $error("program pulse while not busy");
  AST_RD_SAFE: assert property (
    reg_rd && !cpu_req && !nmi_req |=> !nmi_req)
    else $error("register read raised a violation");
  AST_EMERGENCY_EXIT_BIT: assert property (
    reg_wr && reg_addr == `ADDR_CTRL3 && reg_wdata[15:8] == `KEY_WRITE
    && reg_wdata[`C3_EMERGENCY_EXIT_BIT] |-> ##[1:2] !busy)
    else $error("emergency exit did not stop operation");
  AST_MASK: assert property (
    irq_mask |-> busy)
    else $error("interrupts masked while idle");
  cover property (cpu_req && busy && irq_mask);
  cover property ($fell(irq_mask) && busy);
  cover property (puc_req);
endmodule

bind flash_access_guard flash_guard_monitor flash_guard_monitor_inst (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_fetch(cpu_fetch),
  .cpu_rdata(cpu_rdata), .irq_mask(irq_mask), .nmi_req(nmi_req),
  .puc_req(puc_req), .busy(busy), .arr_prog(arr_prog),
  .arr_margin(arr_margin));

// File: sim/flash_array_model.sv
// Flash array model: answers CPU reads, obeys program and erase pulses.
// Assumes word addresses below 16'h0020 and the guard's clock.
`timescale 1ns/100ps
module flash_array_model (
  input  wire logic        clk,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        arr_prog,
  input  wire logic        arr_erase,
  input  wire logic [15:0] arr_addr,
  input  wire logic [15:0] arr_wdata,
  output      logic [15:0] array_rdata
);
  logic [15:0] mem [16];
  initial foreach (mem[i]) mem[i] = 16'hffff;
  assign array_rdata = mem[cpu_addr[4:1]];
  // Programming can only clear bits
  always @(posedge clk) begin
    if (arr_prog)
      mem[arr_addr[4:1]] <= mem[arr_addr[4:1]] & arr_wdata;
    if (arr_erase)
      mem[arr_addr[4:1]] <= 16'hffff;
  end
endmodule

// File: sim/tb.sv
// Bench: register and CPU access sequences with expected values.
// Assumes the array model answers cpu_addr in the same cycle.
`timescale 1ns/100ps
`include "flash_guard_defines.svh"
module tb;
  localparam logic [15:0] A1 = `ADDR_CTRL1;
  localparam logic [15:0] A2 = `ADDR_CTRL2;
  localparam logic [15:0] A3 = `ADDR_CTRL3;
  localparam logic [15:0] A4 = `ADDR_CTRL4;
  logic        clk = 1'b0, reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, cpu_req = 1'b0;
  logic        cpu_wr = 1'b0, cpu_fetch = 1'b0;
  logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
  logic        global_interrupt_enable = 1'b0, irq_pending = 1'b0;
  logic [15:0] reg_rdata, cpu_rdata, array_rdata, arr_addr, arr_wdata;
  logic        irq_mask, nmi_req, puc_req, busy, arr_active;
  logic        arr_prog, arr_erase, arr_mass;
  logic [1:0]  arr_margin;
  logic [15:0] got;
  int          miscompares = 0, checks_done = 0, n;

  always #12.5 clk = ~clk;
  flash_access_guard #(.WRITE_TICKS(60), .BLK_TICKS(3), .SEG_TICKS(80),
    .MASS_TICKS(40)) flash_access_guard_inst (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_fetch(cpu_fetch),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .array_rdata(array_rdata), .global_interrupt_enable(global_interrupt_enable), .irq_pending(irq_pending),
    .irq_mask(irq_mask), .nmi_req(nmi_req), .puc_req(puc_req),
    .busy(busy), .arr_prog(arr_prog), .arr_erase(arr_erase),
    .arr_mass(arr_mass), .arr_active(arr_active), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_margin(arr_margin));
  flash_array_model flash_array_model_inst (
    .clk(clk), .cpu_addr(cpu_addr), .arr_prog(arr_prog),
    .arr_erase(arr_erase), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .array_rdata(array_rdata));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic rc(input logic [15:0] a, input logic [15:0] exp);
    rd(a);
    chk(got, exp);
  endtask
  task automatic cpu(input logic w, input logic f, input logic [15:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    cpu_req   <= 1'b1;
    cpu_wr    <= w;
    cpu_fetch <= f;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_req   <= 1'b0;
    #1 got = cpu_rdata;
  endtask
  task automatic wb;
    for (n = 0; n < 300 && busy !== 1'b0; n++) @(negedge clk);
    chk(16'(busy), 16'h0000);
  endtask
  task automatic ww;
    for (n = 0; n < 30; n++) begin
      rd(A3);
      if (got[3] === 1'b1) break;
    end
    chk(16'(got[3]), 16'h0001);
  endtask
  task automatic test_done;
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #150000;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rc(A1, 16'h9600);
    rc(A2, 16'h9642);
    rc(A3, 16'h9658);
    rc(16'h0200, 16'h0000);
    wr(`ADDR_IE, 16'h0020);
    wr(A2, 16'ha500);
    wr(A3, 16'ha500);
    cpu(1'b1, 1'b0, 16'h0002, 16'h1234);
    chk(16'(nmi_req), 16'h0001);
    rc(A3, 16'h960c);
    cpu(1'b0, 1'b0, 16'h0002, 16'h0000);
    chk(got, 16'hffff);
    wr(A3, 16'ha500);
    chk(16'(nmi_req), 16'h0000);
    wr(A1, 16'ha540);
    cpu(1'b1, 1'b0, 16'h0002, 16'h1234);
    chk(16'(busy), 16'h0001);
    chk(16'(arr_prog), 16'h0001);
    chk(arr_addr, 16'h0002);
    chk(arr_wdata, 16'h1234);
    cpu(1'b0, 1'b1, 16'h0002, 16'h0000);
    chk(got, 16'h3fff);
    cpu(1'b0, 1'b0, 16'h0002, 16'h0000);
    chk(got, 16'h3fff);
    chk(16'(nmi_req), 16'h0000);
    cpu(1'b1, 1'b0, 16'h0004, 16'h0000);
    chk(16'(nmi_req), 16'h0001);
    wr(A3, 16'ha500);
    wr(A1, 16'ha500);
    chk(16'(nmi_req), 16'h0001);
    wr(A3, 16'ha500);
    wr(A2, 16'ha501);
    chk(16'(nmi_req), 16'h0001);
    rc(A1, 16'h9640);
    rc(A2, 16'h9600);
    wb;
    cpu(1'b0, 1'b1, 16'h0002, 16'h0000);
    chk(got, 16'h1234);
    cpu(1'b0, 1'b0, 16'h0004, 16'h0000);
    chk(got, 16'hffff);
    wr(A4, 16'ha510);
    chk(16'(arr_margin), 16'h0001);
    wr(A4, 16'ha520);
    chk(16'(arr_margin), 16'h0002);
    cpu(1'b0, 1'b1, 16'h0002, 16'h0000);
    chk(16'(arr_margin), 16'h0000);
    wr(A3, 16'ha500);
    wr(A1, 16'ha5c0);
    cpu(1'b1, 1'b0, 16'h0006, 16'h00ff);
    ww;
    cpu(1'b1, 1'b0, 16'h0008, 16'h0f0f);
    chk(16'(nmi_req), 16'h0000);
    ww;
    cpu(1'b0, 1'b0, 16'h0006, 16'h0000);
    chk(got, 16'h3fff);
    chk(16'(nmi_req), 16'h0000);
    cpu(1'b0, 1'b1, 16'h0006, 16'h0000);
    rd(A3);
    chk(16'(got[4] & got[2]), 16'h0001);
    wr(A1, 16'ha500);
    wb;
    cpu(1'b0, 1'b0, 16'h0008, 16'h0000);
    chk(got, 16'h0f0f);
    wr(A3, 16'ha500);
    wr(A1, 16'ha552);
    @(posedge clk);
    global_interrupt_enable <= 1'b1;
    cpu(1'b1, 1'b0, 16'h0000, 16'h0000);
    @(posedge clk);
    irq_pending <= 1'b1;
    wb;
    chk(16'(n < 4), 16'h0001);
    @(posedge clk);
    irq_pending <= 1'b0;
    rd(A3);
    chk(16'(got[7]), 16'h0001);
    wr(A1, 16'ha54a);
    cpu(1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(16'(irq_mask), 16'h0001);
    @(posedge clk);
    irq_pending <= 1'b1;
    for (n = 0; n < 200 && irq_mask !== 1'b0; n++) @(negedge clk);
    chk(16'(n >= 28 && n <= 36), 16'h0001);
    chk(16'(busy), 16'h0001);
    chk(16'(arr_active), 16'h0000);
    cpu(1'b0, 1'b0, 16'h0002, 16'h0000);
    chk(got, 16'h1234);
    chk(16'(nmi_req), 16'h0000);
    @(posedge clk);
    irq_pending <= 1'b0;
    wb;
    wr(A1, 16'ha540);
    cpu(1'b1, 1'b0, 16'h000a, 16'h0000);
    wr(A3, 16'ha520);
    @(posedge clk);
    chk(16'(busy), 16'h0000);
    rc(A1, 16'h9600);
    wr(A3, 16'ha500);
    wr(A1, 16'ha544);
    cpu(1'b1, 1'b0, 16'h0008, 16'h0000);
    chk(16'(arr_erase), 16'h0001);
    chk(16'(arr_mass), 16'h0001);
    chk(16'(arr_active), 16'h0001);
    wb;
    cpu(1'b0, 1'b0, 16'h0008, 16'h0000);
    chk(got, 16'hffff);
    wr(A1, 16'h0040);
    chk(16'(puc_req), 16'h0001);
    rc(A3, 16'h965a);
    rc(A1, 16'h9600);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rc(A3, 16'h9658);
    test_done;
  end
endmodule
